// >>> hw/bvp_valve_output.sv
// boundless valve pulse output stage with output conditioning and register port
//
// Our own choices: the address map and the plain strobed port.
`default_nettype none
module bvp_valve_output import bvp_pkg::*; #(
	parameter int TICK_LEN = TICK_CYCLES // cycles per 0.1 s tick
) (
	// clock, reset, enable
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	// register port
	input  wire logic [7:0]   regAddr,
	input  wire logic [31:0]  regWrData,
	input  wire logic         regWr,
	input  wire logic         regRd,
	output logic      [31:0]  regRdData,
	// loop terms and track inputs, same clock
	input  wire bvp_pct_t     propTerm,
	input  wire bvp_pct_t     integTerm,
	input  wire bvp_pct_t     derivTerm,
	input  wire bvp_pct_t     output_follow_input,
	input  wire bvp_pct_t     secondary_follow_input,
	// sensor break pin, asynchronous
	input  wire logic         sensorBreakPin,
	// plant outputs
	output logic              raiseDrive,
	output logic              lowerDrive,
	output bvp_pct_t          channel_one_output,
	output bvp_pct_t          two_state_output
);
	////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic int clampInt(input int v, input int lo, input int hi);
		clampInt = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction
	function automatic int maxInt(input int a, input int b);
		maxInt = (a > b) ? a : b;
	endfunction
	function automatic int minInt(input int a, input int b);
		minInt = (a < b) ? a : b;
	endfunction
	// 16-bit signed percent from the bus, clipped to full scale both ways
	function automatic bvp_pct_t pctIn(input logic [15:0] raw);
		pctIn = 16'(clampInt(int'($signed(raw)), -int'(PCT_FULL), int'(PCT_FULL)));
	endfunction

	////////////////////////////////////////////////////////////////////////
	// configuration registers
	bvp_ctrl_t  ctrl_reg;          // mode bits
	bvp_time_t  travel_reg;        // full stroke time
	bvp_time_t  inertia_reg;       // coast time, zero is off
	bvp_time_t  backlash_reg;      // reversal slack, zero is off
	bvp_time_t  minOn_reg;         // zero selects automatic
	bvp_pct_t   floor_reg;         // output_floor
	bvp_pct_t   ceil_reg;          // output_ceiling
	bvp_time_t  slew_reg;          // output_slew_cap, 0.01 %/s, zero is off
	bvp_pct_t   forced_reg;        // manual_entry_output
	bvp_pct_t   faultLvl_reg;      // fault_output_level
	logic [16:0] band_reg;         // channel_one_switch_band, 0.1 steps
	logic [9:0] deadband_reg;      // deadband, 0.1 steps
	bvp_pct_t   remFloor_reg;      // remote_output_floor
	bvp_pct_t   remCeil_reg;       // remote_output_ceiling
	bvp_pct_t   manualOut_reg;     // manual output value
	bvp_pct_t   workOut_reg;       // conditioned output
	bvp_pct_t   twoState_reg;      // on/off output
	logic [15:0] posTicks_reg;     // estimated position in ticks
	logic [15:0] posPct;           // estimated position in 0.01 %
	logic       manualPrev_reg;    // for manual entry edge
	logic [23:0] tickCnt_reg;      // tick prescaler
	logic       tick;
	logic       sbMeta_reg;        // synchroniser stage one
	logic       sensorBreak_reg;   // synchronised sensor break
	bvp_ctrl_t  wrCtrl;

	assign wrCtrl = bvp_ctrl_t'(regWrData[7:0]);

	// register writes; oversized values are clipped to the legal ranges
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_reg     <= bvp_ctrl_t'(CTRL_RST);
			travel_reg   <= TRAVEL_RST; // [R3]
			inertia_reg  <= TIME_OFF; // [R4]
			backlash_reg <= TIME_OFF; // [R5]
			minOn_reg    <= TIME_OFF; // [R6]
			floor_reg    <= -PCT_FULL;
			ceil_reg     <= PCT_FULL;
			slew_reg     <= TIME_OFF;
			forced_reg   <= PCT_ZERO;
			faultLvl_reg <= PCT_ZERO;
			band_reg     <= 17'h0_0000;
			deadband_reg <= 10'h000;
			remFloor_reg <= -PCT_FULL;
			remCeil_reg  <= PCT_FULL;
		end else if (ce && regWr) begin
			unique case (regAddr)
				ADDR_CTRL:     ctrl_reg <= wrCtrl;
				ADDR_TRAVEL:   travel_reg <= 16'(maxInt(int'(regWrData[15:0]), 1)); // [R3]
				ADDR_INERTIA:  inertia_reg <= regWrData[15:0]; // [R4]
				ADDR_BACKLASH: backlash_reg <= regWrData[15:0]; // [R5]
				ADDR_MINON:    minOn_reg <= regWrData[15:0]; // [R6]
				ADDR_FLOOR:    floor_reg <= pctIn(regWrData[15:0]); // [R11]
				ADDR_CEIL:     ceil_reg <= pctIn(regWrData[15:0]); // [R11]
				ADDR_SLEW:     slew_reg <= 16'(minInt(int'(regWrData[15:0]), SLEW_MAX)); // [R12]
				ADDR_FORCED:   forced_reg <= pctIn(regWrData[15:0]); // [R13]
				ADDR_FAULTLVL: faultLvl_reg <= pctIn(regWrData[15:0]); // [R14]
				ADDR_BAND:     band_reg <= 17'(minInt(int'(regWrData[16:0]), BAND_MAX)); // [R15]
				ADDR_DEADBAND: deadband_reg <= 10'(minInt(int'(regWrData[9:0]), DEADBAND_MAX)); // [R16]
				ADDR_REMFLOOR: remFloor_reg <= pctIn(regWrData[15:0]); // [R17]
				ADDR_REMCEIL:  remCeil_reg <= pctIn(regWrData[15:0]); // [R17]
				default: ;
			endcase
		end
	end

	// read port: data in the cycle after the strobe, unmapped reads zero
	always_ff @(posedge clk) begin
		if (rst) begin
			regRdData <= 32'h0000_0000;
		end else if (ce) begin
			regRdData <= 32'h0000_0000;
			if (regRd) begin
				unique case (regAddr)
					ADDR_CTRL:     regRdData <= {24'h00_0000, ctrl_reg};
					ADDR_TRAVEL:   regRdData <= {16'h0000, travel_reg};
					ADDR_INERTIA:  regRdData <= {16'h0000, inertia_reg};
					ADDR_BACKLASH: regRdData <= {16'h0000, backlash_reg};
					ADDR_MINON:    regRdData <= {16'h0000, minOn_reg};
					ADDR_FLOOR:    regRdData <= {16'h0000, floor_reg};
					ADDR_CEIL:     regRdData <= {16'h0000, ceil_reg};
					ADDR_SLEW:     regRdData <= {16'h0000, slew_reg};
					ADDR_FORCED:   regRdData <= {16'h0000, forced_reg};
					ADDR_FAULTLVL: regRdData <= {16'h0000, faultLvl_reg};
					ADDR_BAND:     regRdData <= {15'h0000, band_reg};
					ADDR_DEADBAND: regRdData <= {22'h00_0000, deadband_reg};
					ADDR_REMFLOOR: regRdData <= {16'h0000, remFloor_reg};
					ADDR_REMCEIL:  regRdData <= {16'h0000, remCeil_reg};
					ADDR_MANUAL:   regRdData <= {16'h0000, manualOut_reg};
					ADDR_POSITION: regRdData <= {16'h0000, posPct}; // [R8]
					ADDR_CHOUT:    regRdData <= {16'h0000, workOut_reg};
					ADDR_TWOSTATE: regRdData <= {16'h0000, twoState_reg};
					default:       regRdData <= 32'h0000_0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// timebase and sensor break synchroniser
	assign tick = ce && (tickCnt_reg == 24'(TICK_LEN - 1));

	always_ff @(posedge clk) begin
		if (rst || tick)
			tickCnt_reg <= 24'h00_0000;
		else if (ce)
			tickCnt_reg <= tickCnt_reg + 24'h00_0001;
	end

	// two flops before any logic reads the pin
	always_ff @(posedge clk) begin
		if (rst) begin
			sbMeta_reg      <= 1'b0;
			sensorBreak_reg <= 1'b0;
		end else if (ce) begin
			sbMeta_reg      <= sensorBreakPin;
			sensorBreak_reg <= sbMeta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output conditioning
	int demand;     // loop demand
	int srcOut;     // selected source
	int loLim;      // effective low limit
	int hiLim;      // effective high limit
	int step;       // slew step per tick
	int workNext;

	// derivative is still an input but drops out of valve drive
	assign demand = int'(propTerm) + int'(integTerm)
		+ (ctrl_reg.boundless ? 0 : int'(derivTerm)); // [R9]

	always_comb begin
		if (sensorBreak_reg)
			srcOut = int'(faultLvl_reg); // [R14]
		else if (ctrl_reg.followEna)
			srcOut = int'(output_follow_input); // [R18]
		else if (ctrl_reg.secFollowEna)
			srcOut = int'(secondary_follow_input); // [R18]
		else if (ctrl_reg.manual)
			srcOut = int'(manualOut_reg); // [R10]
		else
			srcOut = demand;
		loLim = maxInt(int'(floor_reg), int'(remFloor_reg)); // [R11] [R17]
		hiLim = maxInt(loLim, minInt(int'(ceil_reg), int'(remCeil_reg))); // [R11] [R17]
		// rate in 0.01 %/s gives the per-tick step; tiny rates still move
		step = maxInt(int'(slew_reg) / TICKS_PER_S, 1);
		workNext = clampInt(srcOut, loLim, hiLim);
		if (slew_reg != TIME_OFF)
			workNext = clampInt(workNext, int'(workOut_reg) - step,
				int'(workOut_reg) + step); // [R12]
	end

	always_ff @(posedge clk) begin
		if (rst)
			workOut_reg <= PCT_ZERO;
		else if (tick)
			workOut_reg <= 16'(workNext);
	end

	// manual value: forced jump or bumpless hold on entry, then software
	always_ff @(posedge clk) begin
		if (rst) begin
			manualOut_reg  <= PCT_ZERO;
			manualPrev_reg <= 1'b0;
		end else if (ce) begin
			manualPrev_reg <= ctrl_reg.manual;
			if (regWr && regAddr == ADDR_MANUAL)
				manualOut_reg <= pctIn(regWrData[15:0]); // [R10]
			else if (ctrl_reg.manual && !manualPrev_reg)
				manualOut_reg <= ctrl_reg.forcedEnable ? forced_reg : workOut_reg; // [R13]
		end
	end

	// on/off relay with hysteresis; deadband only when channel two exists
	int dbEff;
	int hyst;
	assign dbEff = ctrl_reg.chanTwoEnable ? int'(deadband_reg) * BAND_SCALE : 0; // [R16]
	assign hyst  = int'(band_reg) * BAND_SCALE; // [R15]

	always_ff @(posedge clk) begin
		if (rst)
			twoState_reg <= PCT_ZERO;
		else if (tick) begin
			if (int'(workOut_reg) > hyst)
				twoState_reg <= PCT_FULL; // [R19]
			else if (int'(workOut_reg) < -(dbEff + hyst))
				twoState_reg <= -PCT_FULL; // [R19]
			else if ((twoState_reg == PCT_FULL && int'(workOut_reg) <= 0) ||
				(twoState_reg == -PCT_FULL && int'(workOut_reg) >= -dbEff))
				twoState_reg <= PCT_ZERO; // [R15]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// boundless valve drive, position only estimated from issued pulses
	bvp_state_t  state_reg;
	bvp_state_t  stateNext;
	logic [15:0] pulseLeft_reg;
	logic [15:0] pulseLeftNext;
	logic [15:0] posNext;
	logic        lastUp_reg;     // direction of last pulse
	logic        lastUpNext;
	int minOn;
	int target;
	int need;
	int dur;
	logic faultDrive;

	assign minOn  = (minOn_reg == TIME_OFF) ? int'(MIN_ON_AUTO) : int'(minOn_reg); // [R6]
	assign target = clampInt(int'(workOut_reg), 0, int'(PCT_FULL))
		* int'(travel_reg) / int'(PCT_FULL); // [R3]
	assign need   = target - int'(posTicks_reg); // [R2]
	assign faultDrive = sensorBreak_reg && ctrl_reg.faultAction != FA_RESET;
	assign posPct = 16'(int'(posTicks_reg) * int'(PCT_FULL) / int'(travel_reg)); // [R8]

	always_comb begin
		stateNext     = state_reg;
		pulseLeftNext = pulseLeft_reg;
		posNext       = posTicks_reg;
		lastUpNext    = lastUp_reg;
		dur           = 0;
		unique case (state_reg)
			ST_IDLE: begin
				if (!ctrl_reg.boundless || (sensorBreak_reg && !faultDrive)) begin
					stateNext = ST_IDLE; // [R7]
				end else if (faultDrive) begin
					stateNext     = (ctrl_reg.faultAction == FA_UP) ? ST_RAISE : ST_LOWER; // [R7]
					pulseLeftNext = 16'(minOn);
					lastUpNext    = (ctrl_reg.faultAction == FA_UP);
				end else if (need >= minOn || -need >= minOn) begin
					// smaller errors wait here and grow until worth a pulse
					dur = (need > 0 ? need : -need) - int'(inertia_reg); // [R20] [R4]
					if ((need > 0) != lastUp_reg)
						dur = dur + int'(backlash_reg); // [R5]
					pulseLeftNext = 16'(maxInt(dur, minOn)); // [R6]
					stateNext     = (need > 0) ? ST_RAISE : ST_LOWER; // [R1]
					lastUpNext    = (need > 0);
					posNext       = 16'(target);
				end
			end
			ST_RAISE, ST_LOWER: begin
				if (faultDrive && lastUp_reg == (ctrl_reg.faultAction == FA_UP)) begin
					// keep driving to the end stop, tracking the estimate
					pulseLeftNext = 16'(minOn);
					posNext = 16'(clampInt(int'(posTicks_reg) + (lastUp_reg ? 1 : -1),
						0, int'(travel_reg)));
				end else if (pulseLeft_reg <= 16'h0001 || faultDrive || sensorBreak_reg) begin
					stateNext     = ST_SETTLE; // [R21]
					pulseLeftNext = 16'h0000;
				end else begin
					pulseLeftNext = pulseLeft_reg - 16'h0001;
				end
			end
			ST_SETTLE: stateNext = ST_IDLE; // [R21]
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg     <= ST_IDLE;
			pulseLeft_reg <= 16'h0000;
			posTicks_reg  <= 16'h0000;
			lastUp_reg    <= 1'b1;
		end else if (tick) begin
			state_reg     <= stateNext;
			pulseLeft_reg <= pulseLeftNext;
			posTicks_reg  <= posNext;
			lastUp_reg    <= lastUpNext;
		end
	end

	// plant outputs straight from flops
	always_ff @(posedge clk) begin
		if (rst) begin
			raiseDrive         <= 1'b0;
			lowerDrive         <= 1'b0;
			channel_one_output <= PCT_ZERO;
			two_state_output   <= PCT_ZERO;
		end else if (ce) begin
			raiseDrive         <= (state_reg == ST_RAISE); // [R1] [R21]
			lowerDrive         <= (state_reg == ST_LOWER); // [R1] [R21]
			channel_one_output <= workOut_reg;
			two_state_output   <= twoState_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// ticks of the current pulse, helper for the minimum on-time check
	logic [15:0] onTicks_reg;
	always_ff @(posedge clk) begin
		if (rst || state_reg == ST_IDLE)
			onTicks_reg <= 16'h0000;
		else if (tick && state_reg != ST_SETTLE)
			onTicks_reg <= onTicks_reg + 16'h0001;
	end

	drive_exclusive_a: assert property (!(raiseDrive && lowerDrive)) // [R21]
		else $error("raise and lower driven together");
	reversal_gap_a: assert property ($rose(lowerDrive) |-> !$past(raiseDrive)) // [R21]
		else $error("lower started straight after raise");
	pulse_min_on_a: assert property ( // [R6]
		$fell(state_reg == ST_RAISE) && !sensorBreak_reg |-> int'(onTicks_reg) >= minOn)
		else $error("raise pulse shorter than minimum on-time");
	two_state_set_a: assert property ( // [R19]
		two_state_output == PCT_FULL
		|| two_state_output == -PCT_FULL || two_state_output == PCT_ZERO)
		else $error("on/off output outside three levels");
	// limits are taken from the tick cycle, a limit written on that edge lands later
	output_range_a: assert property ( // [R11]
		tick && slew_reg == TIME_OFF |=> int'(workOut_reg) <= $past(hiLim)
		&& int'(workOut_reg) >= $past(loLim))
		else $error("output outside effective limits");
	slew_step_a: assert property ( // [R12]
		tick && slew_reg != TIME_OFF |=>
		int'(workOut_reg) - int'($past(workOut_reg)) <= $past(step)
		&& int'($past(workOut_reg)) - int'(workOut_reg) <= $past(step))
		else $error("output moved faster than slew cap");
	fault_source_a: assert property (sensorBreak_reg |-> srcOut == int'(faultLvl_reg)) // [R14]
		else $error("sensor break output level not selected");
	follow_source_a: assert property ( // [R18]
		!sensorBreak_reg && ctrl_reg.followEna
		|-> srcOut == int'(output_follow_input))
		else $error("output tracking not followed");
	deriv_ignored_a: assert property ( // [R9]
		ctrl_reg.boundless
		|-> demand == int'(propTerm) + int'(integTerm))
		else $error("derivative reaches boundless drive");
	position_range_a: assert property (posTicks_reg <= travel_reg || $changed(travel_reg)) // [R8]
		else $error("position estimate beyond full stroke");

	raise_pulse_c: cover property ($rose(raiseDrive) ##[1:300] $fell(raiseDrive));
	lower_pulse_c: cover property ($rose(lowerDrive));
	fault_up_c:    cover property (faultDrive && raiseDrive);
	manual_jump_c: cover property (ctrl_reg.manual && !manualPrev_reg && ctrl_reg.forcedEnable);
endmodule // bvp_valve_output
`default_nettype wire

// >>> hw/bvp_pkg.sv
// constants, types and register map of the boundless valve pulse output stage
// Function
// R1 - valve moved only by raise/lower pulses
// R2 - no position feedback needed for drive
// R3 - full-stroke time, 0.1 s steps, default 60 s
// R4 - inertia subtracted from every pulse
// R5 - backlash added when drive direction reverses
// R6 - pulses never shorter than minimum on-time; a sensor break cuts a pulse short
// R7 - sensor break valve action: reset, up, down
// R8 - estimated valve position readable, 0 to 100%
// R9 - derivative term ignored in boundless mode
// R10 - on/off output selectable auto or manual
// R11 - output clamped between low and high limits
// R12 - output slew limited, or unlimited when off
// R13 - manual entry may jump to forced value
// R14 - sensor break drives output to set level
// R15 - on/off relay hysteresis, off means none
// R16 - channel deadband applies only with both channels
// R17 - remote low and high limits also clamp
// R18 - main and auxiliary output tracking enables
// R19 - on/off output only minus full, zero, full
// R20 - short demand accumulated until minimum on-time
// R21 - raise and lower never overlap; reversal ends pulse
`default_nettype none
package bvp_pkg;
	// percent values in 0.01 % steps, times in 0.1 s steps
	typedef logic signed [15:0] bvp_pct_t;
	typedef logic [15:0] bvp_time_t;
	localparam bvp_pct_t  PCT_FULL      = 16'sd10000;
	localparam bvp_pct_t  PCT_ZERO      = 16'sd0;
	localparam int        CLK_PERIOD_NS = 8;
	localparam int        TICK_NS       = 100_000_000;
	localparam int        TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
	localparam int        TICKS_PER_S   = 10;
	localparam int        BAND_SCALE    = 10;
	localparam bvp_time_t TRAVEL_RST    = 16'h0258;
	localparam bvp_time_t MIN_ON_AUTO   = 16'h0002;
	localparam bvp_time_t TIME_OFF      = 16'h0000;
	localparam int        SLEW_MAX      = 9999;   // 99.99 %/s ceiling
	localparam int        BAND_MAX      = 99_999; // 9999.9 in 0.1 steps
	localparam int        DEADBAND_MAX  = 1000;   // 100.0 in 0.1 steps
	// register byte addresses
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_TRAVEL   = 8'h04;
	localparam logic [7:0] ADDR_INERTIA  = 8'h08;
	localparam logic [7:0] ADDR_BACKLASH = 8'h0C;
	localparam logic [7:0] ADDR_MINON    = 8'h10;
	localparam logic [7:0] ADDR_FLOOR    = 8'h14;
	localparam logic [7:0] ADDR_CEIL     = 8'h18;
	localparam logic [7:0] ADDR_SLEW     = 8'h1C;
	localparam logic [7:0] ADDR_FORCED   = 8'h20;
	localparam logic [7:0] ADDR_FAULTLVL = 8'h24;
	localparam logic [7:0] ADDR_BAND     = 8'h28;
	localparam logic [7:0] ADDR_DEADBAND = 8'h2C;
	localparam logic [7:0] ADDR_REMFLOOR = 8'h30;
	localparam logic [7:0] ADDR_REMCEIL  = 8'h34;
	localparam logic [7:0] ADDR_MANUAL   = 8'h38;
	localparam logic [7:0] ADDR_POSITION = 8'h3C;
	localparam logic [7:0] ADDR_CHOUT    = 8'h40;
	localparam logic [7:0] ADDR_TWOSTATE = 8'h44;
	// sensor break valve actions
	typedef enum logic [1:0] {FA_RESET = 2'b00, FA_UP = 2'b01, FA_DOWN = 2'b10} bvp_fault_t;
	// control register layout, bit 7 downward
	typedef struct packed {
		bvp_fault_t faultAction;   // bits 7:6
		logic       chanTwoEnable; // bit 5
		logic       boundless;     // bit 4
		logic       secFollowEna;  // bit 3
		logic       followEna;     // bit 2
		logic       forcedEnable;  // bit 1
		logic       manual;        // bit 0
	} bvp_ctrl_t;
	localparam logic [7:0] CTRL_RST = 8'h10;
	// valve drive states, gray along idle-raise-settle-lower
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00, ST_RAISE = 2'b01, ST_SETTLE = 2'b11, ST_LOWER = 2'b10
	} bvp_state_t;
endpackage : bvp_pkg
`default_nettype wire

// >>> tb/bvp_valve_actuator.sv
// behavioural motorised valve behind the raise and lower relays
`default_nettype none
module bvp_valve_actuator #(
	parameter int STROKE = 800 // cycles for one full stroke
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// relay coils
	input  wire logic raiseDrive,
	input  wire logic lowerDrive,
	// shaft state
	output var  int   shaftPos,
	output var  logic bothOn
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////////////////////////////
	// shaft moves one step a cycle while one coil is on, stops at end stops
	always_ff @(posedge clk) begin
		if (rst) begin
			shaftPos <= 0;
			bothOn   <= 1'b0;
		end else if (raiseDrive && lowerDrive) begin
			bothOn <= 1'b1; // fighting coils would burn the motor, so flag it
		end else if (raiseDrive && shaftPos < STROKE) begin
			shaftPos <= shaftPos + 1;
		end else if (lowerDrive && shaftPos > 0) begin
			shaftPos <= shaftPos - 1;
		end
	end
endmodule // bvp_valve_actuator
`default_nettype wire

// >>> tb/test_boundless_valve_pulse_output.sv
// self-checking bench for the boundless valve pulse output stage
`default_nettype none
module test_boundless_valve_pulse_output import bvp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TL = 8; // short tick keeps pulses of 50 ticks cheap
	// design ports
	logic clk, rst, ce, regWr, regRd, sensorBreakPin, raiseDrive, lowerDrive, bothOn;
	logic [7:0] regAddr;
	logic [31:0] regWrData, regRdData;
	bvp_pct_t propTerm, integTerm, derivTerm, followIn, secIn, chOut, twoOut, prev;
	int shaftPos, num_errors, samples_checked, cycleCount;
	logic [7:0] ra[9] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h18, 8'h30, 8'h34, 8'h3C, 8'h48};
	logic [31:0] re[9] = '{32'h0000_0010, 32'h0000_0258, 32'h0000_0000, 32'h0000_D8F0,
		32'h0000_2710, 32'h0000_D8F0, 32'h0000_2710, 32'h0000_0000, 32'h0000_0000};
	bvp_valve_output #(.TICK_LEN(TL)) uut (.clk(clk), .rst(rst), .ce(ce), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.propTerm(propTerm), .integTerm(integTerm), .derivTerm(derivTerm),
		.output_follow_input(followIn), .secondary_follow_input(secIn),
		.sensorBreakPin(sensorBreakPin), .raiseDrive(raiseDrive), .lowerDrive(lowerDrive),
		.channel_one_output(chOut), .two_state_output(twoOut));
	bvp_valve_actuator #(.STROKE(100 * TL)) valve (.clk(clk), .rst(rst),
		.raiseDrive(raiseDrive), .lowerDrive(lowerDrive), .shaftPos(shaftPos), .bothOn(bothOn));
	////////////////////////////////////////////////////////////////
	// clock and hang guard
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cycleCount++;
		if (cycleCount == 20000) begin // whole run needs far fewer cycles
			num_errors++;
			end_sim();
		end
	end
	////////////////////////////////////////////////////////////////
	// shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr   <= a;
		regWrData <= d;
		regWr     <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(negedge clk);
		check(regRdData, exp);
		@(posedge clk);
	endtask
	task automatic ticks(input int n);
		repeat (n * TL) @(posedge clk);
	endtask
	// wait for one pulse and measure its length in cycles
	task automatic pulse(input logic up, input int n);
		int w;
		int c;
		w = 0;
		c = 0;
		while ((up ? raiseDrive : lowerDrive) !== 1'b1 && w < 8 * TL) begin
			@(negedge clk);
			w++;
		end
		while ((up ? raiseDrive : lowerDrive) === 1'b1 && c < 200 * TL) begin
			@(negedge clk);
			c++;
		end
		check(32'(c), 32'(n * TL));
		@(posedge clk);
	endtask
	// count cycles with any relay on over n ticks
	task automatic quiet(input int n);
		int c;
		c = 0;
		repeat (n * TL) begin
			@(negedge clk);
			if (raiseDrive !== 1'b0 || lowerDrive !== 1'b0) c++;
		end
		check(32'(c), 32'h0000_0000);
		@(posedge clk);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{clk, ce, regWr, regRd, sensorBreakPin} = 5'b01000;
		{propTerm, integTerm, derivTerm, followIn, secIn} = '0;
		{regAddr, regWrData, num_errors, samples_checked, cycleCount} = '0;
		rst = 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 9; i++) rd(ra[i], re[i]);
		wr(ADDR_TRAVEL, 32'h0000_0064);
		rd(ADDR_TRAVEL, 32'h0000_0064);
		$display("test registers done");
		propTerm <= 16'h1388;
		pulse(1'b1, 50);
		check(32'(shaftPos), 32'(50 * TL));
		ticks(2);
		rd(ADDR_POSITION, 32'h0000_1388);
		wr(ADDR_INERTIA, 32'h0000_0005);
		propTerm <= 16'h0BB8;
		pulse(1'b0, 15);
		wr(ADDR_BACKLASH, 32'h0000_0003);
		propTerm <= 16'h0FA0;
		pulse(1'b1, 8);
		wr(ADDR_INERTIA, 32'h0000_0000);
		wr(ADDR_BACKLASH, 32'h0000_0000);
		propTerm <= 16'h1004;
		quiet(6);
		propTerm <= 16'h1068;
		pulse(1'b1, 2);
		$display("test valve done");
		integTerm <= 16'h03E8;
		derivTerm <= 16'h0BB8;
		propTerm  <= 16'h07D0;
		ticks(3);
		check({16'h0000, chOut}, 32'h0000_0BB8);
		check({16'h0000, twoOut}, 32'h0000_2710);
		wr(ADDR_CEIL, 32'h0000_09C4);
		ticks(3);
		check({16'h0000, chOut}, 32'h0000_09C4);
		wr(ADDR_CEIL, 32'h0000_2710);
		wr(ADDR_REMCEIL, 32'h0000_0898);
		ticks(3);
		rd(ADDR_CHOUT, 32'h0000_0898);
		wr(ADDR_FLOOR, 32'h0000_0FA0);
		ticks(3);
		check({16'h0000, chOut}, 32'h0000_0FA0);
		wr(ADDR_FLOOR, 32'h0000_D8F0);
		wr(ADDR_REMCEIL, 32'h0000_2710);
		followIn <= 16'hF830;
		wr(ADDR_CTRL, 32'h0000_0014);
		ticks(3);
		check({16'h0000, chOut}, 32'h0000_F830);
		check({16'h0000, twoOut}, 32'h0000_D8F0);
		secIn <= 16'h05DC;
		wr(ADDR_CTRL, 32'h0000_0018);
		ticks(3);
		check({16'h0000, chOut}, 32'h0000_05DC);
		wr(ADDR_FORCED, 32'h0000_0309);
		wr(ADDR_CTRL, 32'h0000_0013);
		ticks(12);
		check({16'h0000, chOut}, 32'h0000_0309);
		// 1.00 %/s cap moves 0.10 % per tick; exactly one tick falls in any 8 cycles
		wr(ADDR_SLEW, 32'h0000_0064);
		wr(ADDR_MANUAL, 32'h0000_1388);
		ticks(2);
		prev = chOut;
		ticks(1);
		check({16'h0000, 16'(chOut - prev)}, 32'h0000_000A);
		wr(ADDR_SLEW, 32'h0000_0000);
		ticks(2);
		check({16'h0000, chOut}, 32'h0000_1388);
		// a write with the enable low must be lost
		ce <= 1'b0;
		wr(ADDR_MANUAL, 32'h0000_07D0);
		ticks(2);
		ce <= 1'b1;
		check({16'h0000, chOut}, 32'h0000_1388);
		wr(ADDR_BAND, 32'h0000_0064);
		wr(ADDR_MANUAL, 32'h0000_FE0C);
		ticks(3);
		check({16'h0000, twoOut}, 32'h0000_0000);
		wr(ADDR_MANUAL, 32'h0000_01F4);
		ticks(3);
		check({16'h0000, twoOut}, 32'h0000_0000);
		wr(ADDR_DEADBAND, 32'h0000_0032);
		wr(ADDR_CTRL, 32'h0000_0033);
		wr(ADDR_MANUAL, 32'h0000_FB50);
		ticks(3);
		check({16'h0000, twoOut}, 32'h0000_0000);
		wr(ADDR_CTRL, 32'h0000_0013);
		ticks(3);
		check({16'h0000, twoOut}, 32'h0000_D8F0);
		$display("test conditioning done");
		wr(ADDR_FAULTLVL, 32'h0000_04D2);
		wr(ADDR_CTRL, 32'h0000_0050);
		sensorBreakPin <= 1'b1;
		ticks(4);
		check({16'h0000, chOut}, 32'h0000_04D2);
		check({31'h0, raiseDrive}, 32'h0000_0001);
		wr(ADDR_CTRL, 32'h0000_0090);
		ticks(4);
		check({31'h0, lowerDrive}, 32'h0000_0001);
		wr(ADDR_CTRL, 32'h0000_0010);
		ticks(3);
		check({30'h0, raiseDrive, lowerDrive}, 32'h0000_0000);
		sensorBreakPin <= 1'b0;
		check({31'h0, bothOn}, 32'h0000_0000);
		$display("test fault done");
		end_sim();
	end
endmodule // test_boundless_valve_pulse_output
`default_nettype wire
